// ===== hdl/spc_sector_protection_command_unit.sv
// Serial command engine for sector protection bits and their registers
`timescale 1ns/100ps

module spc_sector_protection_command_unit
	import spc_pkg::*;
(
	input  wire logic        mclk_in,            // Core clock
	input  wire logic        srst_in,            // Synchronous reset
	input  wire logic        ce_in,              // Clock enable, freezes state
	input  wire logic        cs_n_in,            // Chip select pin, active low
	input  wire logic        sclk_in,            // Serial clock pin
	input  wire logic        si_in,              // Serial data in pin
	output logic             so_out,             // Serial data out
	output logic             so_oe_out,          // Drive enable for serial out
	input  wire logic        extended_address_flag_in, // Four-byte address mode
	input  wire logic [63:0] password_in,        // Stored password value
	input  wire logic        erase_suspend_in,   // Erase suspend request
	output logic             suspend_rejected_out, // Suspend refused pulse
	input  wire logic [7:0]  sector_sel_in,      // Sector for protect byte view
	output logic [7:0]       protect_byte_out,   // 00h protected, FFh not
	output logic             write_in_progress_out, // Busy flag
	output logic             write_enable_latch_out, // Write enable latch
	output logic [15:0]      protect_config_out, // Config register
	output logic [7:0]       lock_reg_out        // Lock register
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]             cs_sync;   // Chip select synchroniser and delay
		logic [2:0]             sck_sync;  // Serial clock synchroniser and delay
		logic [1:0]             si_sync;   // Data synchroniser
		logic [6:0]             bit_cnt;   // Bits taken this frame
		logic [31:0]            shift_in;  // Last bits taken
		logic [7:0]             opcode;    // Latched opcode
		logic                   rd_act;    // Read-out running
		logic [63:0]            shift_out; // Rotating read-out pattern
		logic                   so;        // Serial out bit
		logic                   so_oe;     // Serial out enable
		logic                   write_enable_latch;       // Write enable latch
		logic                   write_in_progress;       // Operation in progress
		logic [15:0]            busy_cnt;  // Cycles left in operation
		spc_op_t                op;        // Pending operation
		logic [7:0]             sect;      // Target sector
		logic [15:0]            cfg_data;  // Config value to program
		logic [NUM_SECTORS-1:0] persistent_protect_bit;       // Protect bits, 0 = protected
		logic [15:0]            cfg;       // Config register
		logic [7:0]             lock;      // Lock register
		logic                   rej;       // Suspend refused pulse
	} spc_state_t;

	spc_state_t st_reg;  // Registered state
	spc_state_t st_next; // Next state

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Byte order reversal so the low byte leaves first, msb first
	function automatic logic [63:0] low_byte_first(input logic [63:0] v);
		logic [63:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[63-8*i -: 8] = v[8*i +: 8];
		end
		return r;
	endfunction

	// Sector index from an address field
	function automatic logic [7:0] sector_of(input logic [31:0] a);
		return a[SECT_ADDR_LSB +: 8];
	endfunction

	logic sck_rise;  // Synchronised clock rising edge
	logic sck_fall;  // Synchronised clock falling edge
	logic cs_rise;   // End of frame
	logic cs_low;    // Frame active
	logic [7:0] next_opc; // Opcode as it completes

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_next  = st_reg;
		st_next.rej = 1'b0;
		// Pins pass two flops; edges are read only past the first stage
		st_next.cs_sync  = {st_reg.cs_sync[1:0], cs_n_in};
		st_next.sck_sync = {st_reg.sck_sync[1:0], sclk_in};
		st_next.si_sync  = {st_reg.si_sync[0], si_in};
		cs_low   = ~st_reg.cs_sync[1];
		cs_rise  = st_reg.cs_sync[1] & ~st_reg.cs_sync[2];
		sck_rise = st_reg.sck_sync[1] & ~st_reg.sck_sync[2];
		sck_fall = ~st_reg.sck_sync[1] & st_reg.sck_sync[2];
		next_opc = {st_reg.shift_in[6:0], st_reg.si_sync[1]};

		// Serial input on rising clock edges
		if (cs_low && sck_rise) begin
			st_next.shift_in = {st_reg.shift_in[30:0], st_reg.si_sync[1]};
			if (st_reg.bit_cnt != BITS_MAX) begin
				st_next.bit_cnt = st_reg.bit_cnt + 7'h01;
			end
			if (st_reg.bit_cnt == BITS_OPCODE - 7'h01) begin
				st_next.opcode = next_opc;
				// Read commands load a pattern that repeats over 64 bits
				case (next_opc)
					OPC_READ_CONFIG: begin
						st_next.rd_act    = 1'b1;
						st_next.shift_out = {4{st_reg.cfg[7:0], st_reg.cfg[15:8]}};
					end
					OPC_READ_LOCK: begin
						st_next.rd_act    = 1'b1;
						st_next.shift_out = {8{st_reg.lock}};
					end
					OPC_READ_PASSWORD: begin
						// Locked password mode: stay silent
						st_next.rd_act    = st_reg.cfg[PWD_MODE_POS];
						st_next.shift_out = low_byte_first(password_in);
					end
					default: begin
						st_next.rd_act = 1'b0;
					end
				endcase
			end
		end

		// Serial output on falling edges, rotated so the value repeats
		if (cs_low && sck_fall && st_reg.rd_act) begin
			st_next.so        = st_reg.shift_out[63];
			st_next.so_oe     = 1'b1;
			st_next.shift_out = {st_reg.shift_out[62:0], st_reg.shift_out[63]};
		end

		// Operation timer; effects land when it expires
		if (st_reg.write_in_progress) begin
			if (st_reg.busy_cnt > 16'h0001) begin
				st_next.busy_cnt = st_reg.busy_cnt - 16'h0001;
			end else begin
				st_next.busy_cnt = '0;
				st_next.write_in_progress      = 1'b0;
				st_next.write_enable_latch      = 1'b0;
				st_next.op       = SPC_OP_NONE;
				case (st_reg.op)
					SPC_OP_PROG:   st_next.persistent_protect_bit[st_reg.sect] = 1'b0;
					SPC_OP_ERASE:  st_next.persistent_protect_bit = '1;
					SPC_OP_CFG:    st_next.cfg = st_reg.cfg_data;
					SPC_OP_CLRLK:  st_next.lock[LOCK_BIT_POS] = 1'b0;
					SPC_OP_FREEZE: st_next.lock[FREEZE_BIT_POS] = 1'b1;
					default:       st_next.op = SPC_OP_NONE;
				endcase
			end
		end

		// Suspend has no effect on protect erase; flag the refusal
		if (erase_suspend_in && st_reg.write_in_progress && st_reg.op == SPC_OP_ERASE) begin
			st_next.rej = 1'b1;
		end

		// End of frame: decode by exact bit count
		if (cs_rise) begin
			st_next.bit_cnt = '0;
			st_next.rd_act  = 1'b0;
			st_next.so_oe   = 1'b0;
			// Writes only when idle and latched
			if (!st_reg.write_in_progress) begin
				case (st_reg.opcode)
					OPC_WRITE_ENABLE: begin
						if (st_reg.bit_cnt == BITS_OPCODE) begin
							st_next.write_enable_latch = 1'b1;
						end
					end
					OPC_PROG_PROT, OPC_PROG_PROT_WIDE: begin
						// Start at select rise after the last address bit
						if (st_reg.write_enable_latch && st_reg.lock[LOCK_BIT_POS] &&
						    st_reg.bit_cnt == ((st_reg.opcode == OPC_PROG_PROT_WIDE ||
						    extended_address_flag_in) ? BITS_ADDR4 : BITS_ADDR3)) begin
							st_next.write_in_progress      = 1'b1;
							st_next.op       = SPC_OP_PROG;
							st_next.busy_cnt = PROG_CYCLES;
							// Only the sector field is used; base offset assumed
							st_next.sect     = sector_of(st_reg.shift_in);
						end
					end
					OPC_ERASE_PROT: begin
						if (st_reg.write_enable_latch && st_reg.lock[LOCK_BIT_POS] &&
						    st_reg.bit_cnt == BITS_OPCODE) begin
							st_next.write_in_progress      = 1'b1;
							st_next.op       = SPC_OP_ERASE;
							st_next.busy_cnt = ERASE_CYCLES;
						end
					end
					OPC_PROG_CONFIG: begin
						if (st_reg.write_enable_latch && st_reg.bit_cnt == BITS_CFG_DATA) begin
							st_next.write_in_progress      = 1'b1;
							st_next.op       = SPC_OP_CFG;
							st_next.busy_cnt = PROG_CYCLES;
							// First byte sent is the low byte
							st_next.cfg_data = {st_reg.shift_in[7:0], st_reg.shift_in[15:8]};
						end
					end
					OPC_CLEAR_LOCK, OPC_SET_FREEZE: begin
						if (st_reg.write_enable_latch && st_reg.bit_cnt == BITS_OPCODE) begin
							st_next.write_in_progress      = 1'b1;
							st_next.op       = (st_reg.opcode == OPC_CLEAR_LOCK) ?
							                   SPC_OP_CLRLK : SPC_OP_FREEZE;
							st_next.busy_cnt = PROG_CYCLES;
						end
					end
					default: begin
						st_next.op = st_reg.op;
					end
				endcase
			end
			st_next.opcode = '0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Select synchroniser stages reset high to match idle select; clock and data stages reset low
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			st_reg          <= '0;
			st_reg.cs_sync  <= 3'h7;
			st_reg.op       <= SPC_OP_NONE;
			st_reg.persistent_protect_bit      <= '1;
			st_reg.cfg      <= CONFIG_RESET;
			st_reg.lock     <= LOCK_RESET;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign so_out                 = st_reg.so;
	assign so_oe_out              = st_reg.so_oe;
	assign suspend_rejected_out   = st_reg.rej;
	assign write_in_progress_out  = st_reg.write_in_progress;
	assign write_enable_latch_out = st_reg.write_enable_latch;
	assign protect_config_out     = st_reg.cfg;
	assign lock_reg_out           = st_reg.lock;
	// Byte view of the selected bit
	assign protect_byte_out = st_reg.persistent_protect_bit[sector_sel_in] ? PROT_BYTE_OFF : PROT_BYTE_ON;

endmodule

// ===== hdl/spc_pkg.sv
// Constants and types for the sector protection command unit
package spc_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE_ENABLE    = 8'h06; // Write enable
	localparam logic [7:0] OPC_PROG_PROT       = 8'hfd; // Program protect bit
	localparam logic [7:0] OPC_PROG_PROT_WIDE  = 8'he3; // Program, 4-byte address
	localparam logic [7:0] OPC_ERASE_PROT      = 8'he4; // Erase all protect bits
	localparam logic [7:0] OPC_READ_CONFIG     = 8'h2b; // Read config register
	localparam logic [7:0] OPC_PROG_CONFIG     = 8'h2f; // Program config register
	localparam logic [7:0] OPC_READ_LOCK       = 8'ha7; // Read lock register
	localparam logic [7:0] OPC_CLEAR_LOCK      = 8'ha6; // Clear lock bit
	localparam logic [7:0] OPC_SET_FREEZE      = 8'h91; // Set freeze bit
	localparam logic [7:0] OPC_READ_PASSWORD   = 8'he7; // Read password

	// ------------------------------------------------------------
	// Frame lengths in serial bits, opcode included
	// ------------------------------------------------------------
	localparam logic [6:0] BITS_OPCODE   = 7'h08; // Opcode only
	localparam logic [6:0] BITS_ADDR3    = 7'h20; // Opcode plus 3 address bytes
	localparam logic [6:0] BITS_ADDR4    = 7'h28; // Opcode plus 4 address bytes
	localparam logic [6:0] BITS_CFG_DATA = 7'h18; // Opcode plus 2 data bytes
	localparam logic [6:0] BITS_MAX      = 7'h7f; // Saturation of the bit counter

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          LOCK_BIT_POS    = 0;        // Protect lock bit
	localparam int          FREEZE_BIT_POS  = 7;        // Freeze flag
	localparam int          PWD_MODE_POS    = 2;        // Password mode bit in config
	localparam int          SECT_ADDR_LSB   = 16;       // Sector index field of address
	localparam logic [15:0] CONFIG_RESET    = 16'hffff; // Factory config value
	localparam logic [7:0]  LOCK_RESET      = 8'h01;    // Lock bit set, not frozen
	localparam logic [7:0]  PROT_BYTE_ON    = 8'h00;    // Sector protected
	localparam logic [7:0]  PROT_BYTE_OFF   = 8'hff;    // Sector unprotected
	localparam int          NUM_SECTORS     = 256;      // Protect bits held

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;    // Core clock period
	localparam int PROG_TIME_NS   = 5000;  // Short nonvolatile write
	localparam int ERASE_TIME_NS  = 20000; // Pre-program plus erase
	localparam logic [15:0] PROG_CYCLES  = 16'(PROG_TIME_NS / CLK_PERIOD_NS);
	localparam logic [15:0] ERASE_CYCLES = 16'(ERASE_TIME_NS / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Internal operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SPC_OP_NONE   = 3'b000,
		SPC_OP_PROG   = 3'b001,
		SPC_OP_ERASE  = 3'b010,
		SPC_OP_CFG    = 3'b011,
		SPC_OP_CLRLK  = 3'b100,
		SPC_OP_FREEZE = 3'b101
	} spc_op_t;

endpackage

// ===== testbench/spc_checker_sva.sv
// Port-level assertions for the sector protection command unit
`timescale 1ns/100ps
module spc_checker
	import spc_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        srst_in,
	input wire logic        cs_n_in,
	input wire logic        sclk_in,
	input wire logic        erase_suspend_in,
	input wire logic        so_out,
	input wire logic        so_oe_out,
	input wire logic        suspend_rejected_out,
	input wire logic        write_in_progress_out,
	input wire logic        write_enable_latch_out,
	input wire logic [15:0] protect_config_out,
	input wire logic [7:0]  lock_reg_out
);
	// ----------------------------------------
	// Busy cycle counter
	// ----------------------------------------
	logic [15:0] busy_cnt_reg; // Cycles busy so far, zero when idle
	always_ff @(posedge mclk_in) begin
		if (srst_in || !write_in_progress_out) busy_cnt_reg <= 16'h0000;
		else busy_cnt_reg <= busy_cnt_reg + 16'h0001;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	wel_clears_end_a: assert property (
		$fell(write_in_progress_out) |-> $fell(write_enable_latch_out))
		else $error("latch not cleared as operation ends");
	busy_time_a: assert property ($fell(write_in_progress_out) |->
		busy_cnt_reg inside {[PROG_CYCLES-3:PROG_CYCLES+3], [ERASE_CYCLES-3:ERASE_CYCLES+3]})
		else $error("operation length off");
	start_needs_wel_a: assert property (
		$rose(write_in_progress_out) |-> $past(write_enable_latch_out))
		else $error("operation started without latch");
	start_cs_high_a: assert property (
		$rose(write_in_progress_out) |-> cs_n_in && $past(cs_n_in))
		else $error("operation started with select low");
	reject_cause_a: assert property (suspend_rejected_out |->
		$past(erase_suspend_in) && $past(write_in_progress_out))
		else $error("refusal pulse without cause");
	reject_erase_a: assert property (
		erase_suspend_in && busy_cnt_reg > PROG_CYCLES + 16'h0008 |=> suspend_rejected_out)
		else $error("suspend during erase not refused");
	oe_idle_a: assert property (cs_n_in [*5] |-> !so_oe_out)
		else $error("output driven while deselected");
	so_on_fall_a: assert property ($changed(so_out) |-> !sclk_in)
		else $error("serial out moved with clock high");
	cfg_at_end_a: assert property (
		$changed(protect_config_out) |-> $fell(write_in_progress_out))
		else $error("config changed outside operation end");
	lock_at_end_a: assert property (
		$changed(lock_reg_out) |-> $fell(write_in_progress_out))
		else $error("lock register changed outside operation end");
endmodule

// ===== testbench/spc_host_model.sv
// Serial host model driving select, clock and data in mode 0
`timescale 1ns/100ps
module spc_host_model (
	input  wire logic mclk_in,
	input  wire logic so_in,
	input  wire logic so_oe_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      si_out
);
	logic oe_seen; // Output enable observed in last frame
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out   = 1'b0;
		oe_seen  = 1'b0;
	end
	// ----------------------------------------
	// One frame: n bits sent MSB first, n bits captured
	// ----------------------------------------
	task automatic xfer(input logic [127:0] tx, input int n, output logic [127:0] rx);
		rx = '0;
		oe_seen = 1'b0;
		@(negedge mclk_in) cs_n_out <= 1'b0;
		// 160 ns link period: 8 core clocks low, 8 high
		for (int i = n - 1; i >= 0; i--) begin
			sclk_out <= 1'b0;
			si_out   <= tx[i]; // Data set as clock falls, stable at rise
			repeat (8) @(negedge mclk_in);
			sclk_out <= 1'b1;
			rx = {rx[126:0], so_in}; // Bit launched on previous fall
			oe_seen = oe_seen | so_oe_in;
			repeat (8) @(negedge mclk_in);
		end
		sclk_out <= 1'b0;
		// Select rises right after the last bit
		repeat (8) @(negedge mclk_in);
		cs_n_out <= 1'b1;
		si_out   <= ~si_out; // Released line shows no stale value
		repeat (8) @(negedge mclk_in);
	endtask
endmodule

// ===== testbench/testbench.sv
// Command-level bench for the sector protection command unit
`timescale 1ns/100ps
module testbench;
	import spc_pkg::*;
	logic mclk_in, srst_in, ce_in, cs_n, sclk, si, so, so_oe, ext, sus, rej, write_in_progress, write_enable_latch;
	logic [63:0]  pw;
	logic [7:0]   sel, pbyte, lock;
	logic [15:0]  cfg;
	logic [127:0] rx;
	logic [63:0]  pexp;
	int mismatches, samples_checked, cycles;
	spc_sector_protection_command_unit dut_u (.mclk_in(mclk_in), .srst_in(srst_in),
		.ce_in(ce_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si), .so_out(so),
		.so_oe_out(so_oe), .extended_address_flag_in(ext), .password_in(pw),
		.erase_suspend_in(sus), .suspend_rejected_out(rej), .sector_sel_in(sel),
		.protect_byte_out(pbyte), .write_in_progress_out(write_in_progress),
		.write_enable_latch_out(write_enable_latch), .protect_config_out(cfg), .lock_reg_out(lock));
	spc_host_model host_u (.mclk_in(mclk_in), .so_in(so), .so_oe_in(so_oe),
		.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
			mismatches++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [127:0] tx, input int n, input logic busy);
		host_u.xfer(128'h06, 8, rx); // Write enable first
		host_u.xfer(tx, n, rx);
		chk("wip", write_in_progress, busy);
	endtask
	task automatic idle();
		for (int i = 0; i < 3000 && write_in_progress !== 1'b0; i++) @(negedge mclk_in);
		chk("idle", {write_in_progress, write_enable_latch}, 2'b00);
	endtask
	initial begin
		cycles = 0;
		forever begin
			@(posedge mclk_in) cycles++;
			if (cycles > 40000) begin
				mismatches++;
				print_verdict();
			end
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [39:0] ptx [3] = '{{8'hfd, 24'h050000, 8'h00}, {8'he3, 32'h000a0000},
			{8'hfd, 32'h000c0000}};
		int          pn [3]  = '{32, 40, 40};
		logic [7:0]  psec [3] = '{8'h05, 8'h0a, 8'h0c};
		logic        pext [3] = '{1'b0, 1'b0, 1'b1};
		mismatches = 0;
		samples_checked = 0;
		srst_in = 1'b1;
		ce_in = 1'b1;
		ext = 1'b0;
		sus = 1'b0;
		sel = 8'h00;
		pw = 64'h0123456789abcdef; // Arbitrary password
		for (int k = 0; k < 8; k++) pexp[63 - 8 * k -: 8] = pw[8 * k +: 8];
		repeat (5) @(negedge mclk_in);
		srst_in = 1'b0;
		repeat (4) @(negedge mclk_in);
		chk("reset", {write_in_progress, write_enable_latch, cfg, lock, pbyte}, {2'b00, 16'hffff, 8'h01, 8'hff});
		// Frozen core must ignore a whole write enable frame
		ce_in = 1'b0;
		host_u.xfer(128'h06, 8, rx);
		ce_in = 1'b1;
		chk("frozen", write_enable_latch, 1'b0);
		host_u.xfer(128'he4, 8, rx);
		chk("no latch", write_in_progress, 1'b0);
		wr(128'h1c8, 9, 1'b0);
		chk("wel", write_enable_latch, 1'b1);
		for (int i = 0; i < 3; i++) begin
			ext = pext[i];
			wr(ptx[i] >> (40 - pn[i]), pn[i], 1'b1);
			idle();
			sel = psec[i];
			@(negedge mclk_in) chk("prot", pbyte, 8'h00);
			sel = psec[i] + 8'h01;
			@(negedge mclk_in) chk("unprot", pbyte, 8'hff);
		end
		wr(128'he4, 8, 1'b1);
		repeat (700) @(negedge mclk_in);
		sus = 1'b1;
		@(negedge mclk_in) chk("suspend", rej, 1'b1);
		sus = 1'b0;
		idle();
		sel = 8'h05;
		@(negedge mclk_in) chk("erased", pbyte, 8'hff);
		host_u.xfer({8'h2b, 32'h0}, 40, rx);
		chk("cfg read", rx[31:0], 32'hffffffff);
		host_u.xfer({8'he7, 80'h0}, 88, rx);
		chk("pwd", rx[79:0], {pexp, pexp[63:48]});
		wr(128'h17fdff, 23, 1'b0);
		wr(128'h2ffbff, 24, 1'b1);
		idle();
		chk("cfg", cfg, 16'hfffb);
		host_u.xfer({8'h2b, 32'h0}, 40, rx);
		chk("cfg read", rx[31:0], 32'hfbfffbff);
		host_u.xfer({8'he7, 64'h0}, 72, rx);
		chk("pwd off", host_u.oe_seen, 1'b0);
		host_u.xfer({8'ha7, 16'h0}, 24, rx);
		chk("lock read", rx[15:0], 16'h0101);
		wr(128'ha6, 8, 1'b1);
		idle();
		wr(128'h91, 8, 1'b1);
		idle();
		host_u.xfer({8'ha7, 16'h0}, 24, rx);
		chk("lock", {lock, rx[15:0]}, 24'h808080);
		print_verdict();
	end
endmodule
bind spc_sector_protection_command_unit spc_checker chk_u (.mclk_in(mclk_in),
	.srst_in(srst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
	.erase_suspend_in(erase_suspend_in), .so_out(so_out), .so_oe_out(so_oe_out),
	.suspend_rejected_out(suspend_rejected_out),
	.write_in_progress_out(write_in_progress_out),
	.write_enable_latch_out(write_enable_latch_out),
	.protect_config_out(protect_config_out), .lock_reg_out(lock_reg_out));
